// >>> include/temp_warn_pkg.sv
// package: register map, field layout, timing and carrier types for the warning comparator
package temp_warn_pkg;

  // register byte offsets on the wishbone slave (word aligned); THRESHOLD_OFFSET is a word index, not a byte offset
  localparam logic [15:0] THRESHOLD_OFFSET   = 16'hFE1A;
  // index times four; the top two index bits do not fit the 16-bit address
  localparam logic [15:0] THRESHOLD_ADDR     = {THRESHOLD_OFFSET[13:0], 2'b00};
  localparam logic [15:0] STATUS_ADDR        = 16'h3870;
  localparam logic [15:0] IRQ_STATUS_ADDR    = 16'h3874;
  localparam logic [15:0] IRQ_MASK_ADDR      = 16'h3878;
  localparam logic [15:0] READING_ADDR       = 16'h387C;

  // reset values
  localparam logic [7:0]  THRESHOLD_RESET    = 8'h03;
  localparam logic [1:0]  IRQ_MASK_RESET     = 2'h0;
  localparam logic [1:0]  IRQ_STATUS_RESET   = 2'h0;

  // field positions
  localparam int          STAT_WARN_BIT      = 0;
  localparam int          STAT_RAW_BIT       = 1;
  localparam int          IRQ_SET_BIT        = 0;
  localparam int          IRQ_CLR_BIT        = 1;

  // converter and threshold widths
  localparam int          READING_WIDTH      = 12;
  localparam int          COMPARE_WIDTH      = 9;

  // threshold code limits permitted to software, and step size in nanovolts
  localparam logic [7:0]  THRESHOLD_MIN      = 8'h03;
  localparam logic [7:0]  THRESHOLD_MAX      = 8'hFA;
  localparam int          STEP_NANOVOLT      = 3125000;

  // debounce timing
  localparam longint      CLOCK_HZ           = 20000000;
  localparam longint      DEBOUNCE_MS        = 100;
  localparam longint      DEBOUNCE_CYCLES    = (DEBOUNCE_MS * CLOCK_HZ) / 1000;

  // wishbone request carrier
  typedef struct packed
  {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [15:0] adr;
    logic [31:0] dat;
  } wb_req_type;

  // wishbone answer carrier
  typedef struct packed
  {
    logic        ack;
    logic        err;
    logic [31:0] dat;
  } wb_rsp_type;

endpackage

// >>> hdl/warn_debounce.sv
// debounce filter: output follows input only after a full quiet interval
`timescale 1ns/1ns
module warn_debounce #(
  parameter int unsigned HOLD_CYCLES = 32'(temp_warn_pkg::DEBOUNCE_CYCLES)
)(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic raw_in,
  output logic      filt_out
);

  logic [31:0] count_ff;
  logic [31:0] nxt_count;
  logic        filt_ff;
  wire  logic  differs  = raw_in != filt_ff;
  wire  logic  expired  = count_ff >= HOLD_CYCLES - 32'd1;

  // counter restarts whenever input agrees with output, so a glitch resets it
  assign nxt_count = (differs && !expired) ? count_ff + 32'd1 : 32'd0;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_ff <= 32'd0;
      filt_ff  <= 1'b0;
    end
    else
    begin
      count_ff <= nxt_count;
      if (differs && expired)
        filt_ff <= raw_in;
    end
  end

  assign filt_out = filt_ff;

endmodule // warn_debounce

// >>> hdl/warn_compare.sv
// threshold compare: zero-extended code against upper converter bits
`timescale 1ns/1ns
module warn_compare (
  input  wire logic [7:0]                               threshold,
  input  wire logic [temp_warn_pkg::READING_WIDTH-1:0]  reading,
  output logic                                          below
);

  wire logic [temp_warn_pkg::COMPARE_WIDTH-1:0] ext_threshold;
  wire logic [temp_warn_pkg::COMPARE_WIDTH-1:0] top_reading;

  // extra msb of zero makes the compare unsigned over 9 bits
  assign ext_threshold = {1'b0, threshold};
  // low converter bits are dropped, not rounded
  assign top_reading   = reading[temp_warn_pkg::READING_WIDTH-1 -:
                                 temp_warn_pkg::COMPARE_WIDTH];
  assign below         = top_reading < ext_threshold;

endmodule // warn_compare

// >>> hdl/overtemp_warning_compare.sv
// top: wishbone registers, compare, debounce and interrupt for the overtemperature warning
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/1ns
// Behaviour
// - warning flag debounced over 100 ms
// - threshold zero-extended to nine bits
// - compare against upper nine converter bits
// - warning set when reading below threshold
// - one code step is 3.125 mV
module overtemp_warning_compare #(
  parameter int unsigned DEBOUNCE_LEN = 32'(temp_warn_pkg::DEBOUNCE_CYCLES)
)(
  input  wire logic                                     core_clk,
  input  wire logic                                     reset_n,
  input  wire temp_warn_pkg::wb_req_type                wb_req,
  output temp_warn_pkg::wb_rsp_type                     wb_rsp,
  input  wire logic [temp_warn_pkg::READING_WIDTH-1:0]  sensor_reading,
  output logic                                          temp_warning,
  output logic                                          irq
);

  ////////////////////////////////////////////////////////////////
  // register state
  logic [7:0]  threshold_ff;
  logic [1:0]  irq_status_ff;
  logic [1:0]  irq_mask_ff;
  logic        ack_ff;
  logic        err_ff;
  logic [31:0] rdata_ff;
  logic        warn_prev_ff;
  logic [31:0] nxt_rdata;

  wire logic   raw_below;
  wire logic   warn_flag;
  wire logic [1:0] nxt_irq_status;

  ////////////////////////////////////////////////////////////////
  // bus decode: one-cycle wait, ack in the cycle after the request
  wire logic   req      = wb_req.cyc && wb_req.stb && !ack_ff && !err_ff;
  wire logic   hit_thr  = wb_req.adr == temp_warn_pkg::THRESHOLD_ADDR;
  wire logic   hit_stat = wb_req.adr == temp_warn_pkg::STATUS_ADDR;
  wire logic   hit_irqs = wb_req.adr == temp_warn_pkg::IRQ_STATUS_ADDR;
  wire logic   hit_mask = wb_req.adr == temp_warn_pkg::IRQ_MASK_ADDR;
  wire logic   hit_rd   = wb_req.adr == temp_warn_pkg::READING_ADDR;
  wire logic   mapped   = hit_thr || hit_stat || hit_irqs || hit_mask || hit_rd;
  wire logic   wr_lane0 = req && wb_req.we && wb_req.sel[0];
  wire logic   wr_thr   = wr_lane0 && hit_thr;
  wire logic   wr_irqs  = wr_lane0 && hit_irqs;
  wire logic   wr_mask  = wr_lane0 && hit_mask;

  // events: warning rises and warning falls
  wire logic   ev_set   = warn_flag && !warn_prev_ff;
  wire logic   ev_clr   = !warn_flag && warn_prev_ff;
  wire logic [1:0] events = {ev_clr, ev_set};
  wire logic [1:0] w1c    = wr_irqs ? wb_req.dat[1:0] : 2'h0;

  // one sticky bit per event; a new event wins over a write-one-to-clear
  // in the same cycle, so an edge is never lost to a racing clear
  for (genvar b = 0; b < 2; b++)
  begin : g_status
    assign nxt_irq_status[b] = (irq_status_ff[b] && !w1c[b]) || events[b];
  end

  // read mux; unused bits read zero
  assign nxt_rdata =
    hit_thr  ? {24'h000000, threshold_ff} :
    hit_stat ? {30'h00000000, raw_below, warn_flag} :
    hit_irqs ? {30'h00000000, irq_status_ff} :
    hit_mask ? {30'h00000000, irq_mask_ff} :
    hit_rd   ? {20'h00000, sensor_reading} : 32'h00000000;

  ////////////////////////////////////////////////////////////////
  // bus answer registers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_ff   <= 1'b0;
      err_ff   <= 1'b0;
      rdata_ff <= 32'h00000000;
    end
    else
    begin
      ack_ff   <= req && mapped;
      err_ff   <= req && !mapped;  // unmapped addresses answer with err
      rdata_ff <= (req && !wb_req.we) ? nxt_rdata : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////
  // software registers; codes outside 0x03..0xFA are stored unchanged,
  // keeping the limit is software's job
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      threshold_ff  <= temp_warn_pkg::THRESHOLD_RESET;
      irq_mask_ff   <= temp_warn_pkg::IRQ_MASK_RESET;
      irq_status_ff <= temp_warn_pkg::IRQ_STATUS_RESET;
      warn_prev_ff  <= 1'b0;
    end
    else
    begin
      if (wr_thr)
        threshold_ff <= wb_req.dat[7:0];
      if (wr_mask)
        irq_mask_ff <= wb_req.dat[1:0];
      irq_status_ff <= nxt_irq_status;
      warn_prev_ff  <= warn_flag;
    end
  end

  ////////////////////////////////////////////////////////////////
  // compare and debounce
  warn_compare u_compare (
    .threshold (threshold_ff),
    .reading   (sensor_reading),
    .below     (raw_below)
  );

  warn_debounce #(
    .HOLD_CYCLES (DEBOUNCE_LEN)
  ) u_debounce (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .raw_in   (raw_below),
    .filt_out (warn_flag)
  );

  ////////////////////////////////////////////////////////////////
  // outputs
  assign wb_rsp       = {ack_ff, err_ff, rdata_ff};
  assign temp_warning = warn_flag;
  assign irq          = |(irq_status_ff & irq_mask_ff);

  ////////////////////////////////////////////////////////////////
  // assertions
  // cycles the raw compare has disagreed with the flag since the flag last
  // moved; restarting on a flag change keeps a reading that flips right at
  // the change from being counted on top of the finished interval
  int unsigned hold_cnt;
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      hold_cnt <= 0;
    else if (raw_below == warn_flag)
      hold_cnt <= 0;
    else if (warn_flag != warn_prev_ff)
      hold_cnt <= 1;
    else
      hold_cnt <= hold_cnt + 1;
  end

  sequence s_below_steady;
    raw_below [*3];
  endsequence

  property p_no_early_set;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(warn_flag) |-> hold_cnt == DEBOUNCE_LEN;
  endproperty
  a_no_early_set: assert property (p_no_early_set) else $error("warning rose too soon");

  property p_no_early_clear;
    @(posedge core_clk) disable iff (!reset_n)
      $fell(warn_flag) |-> hold_cnt == DEBOUNCE_LEN;
  endproperty
  a_no_early_clear: assert property (p_no_early_clear) else $error("warning fell too soon");

  property p_no_late_change;
    @(posedge core_clk) disable iff (!reset_n)
      hold_cnt <= DEBOUNCE_LEN;
  endproperty
  a_no_late_change: assert property (p_no_late_change) else $error("debounce overran");

  property p_compare;
    @(posedge core_clk) disable iff (!reset_n)
      raw_below == ({3'b000, sensor_reading[11:3]} < {4'h0, threshold_ff});
  endproperty
  a_compare: assert property (p_compare) else $error("compare mismatch");

  property p_low_bits_ignored;
    @(posedge core_clk) disable iff (!reset_n)
      $stable(sensor_reading[11:3]) && $stable(threshold_ff) |-> $stable(raw_below);
  endproperty
  a_low_bits_ignored: assert property (p_low_bits_ignored) else $error("low bits leaked");

  property p_msb_zero;
    @(posedge core_clk) disable iff (!reset_n)
      sensor_reading[11] |-> !raw_below;
  endproperty
  a_msb_zero: assert property (p_msb_zero) else $error("threshold not zero-extended");

  property p_thr_write;
    @(posedge core_clk) disable iff (!reset_n)
      wr_thr |=> threshold_ff == $past(wb_req.dat[7:0]) && ack_ff;
  endproperty
  a_thr_write: assert property (p_thr_write) else $error("threshold write lost");

  property p_irq_set;
    @(posedge core_clk) disable iff (!reset_n)
      $rose(warn_flag) |=> irq_status_ff[0];
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("set event not latched");

  property p_steady_no_toggle;
    @(posedge core_clk) disable iff (!reset_n)
      s_below_steady ##0 warn_flag |=> warn_flag;
  endproperty
  a_steady_no_toggle: assert property (p_steady_no_toggle) else $error("flag dropped");

  ////////////////////////////////////////////////////////////////
  // bus answer: one pulse per taken request, ack if mapped, err if not
  property p_ack_taken;
    @(posedge core_clk) disable iff (!reset_n)
      req && mapped |=> ack_ff && !err_ff;
  endproperty
  a_ack_taken: assert property (p_ack_taken) else $error("mapped request not acked");

  property p_err_taken;
    @(posedge core_clk) disable iff (!reset_n)
      req && !mapped |=> err_ff && !ack_ff;
  endproperty
  a_err_taken: assert property (p_err_taken) else $error("unmapped request not refused");

  property p_no_stray_answer;
    @(posedge core_clk) disable iff (!reset_n)
      !req |=> !ack_ff && !err_ff;
  endproperty
  a_no_stray_answer: assert property (p_no_stray_answer) else $error("answer without request");

  property p_ack_pulse;
    @(posedge core_clk) disable iff (!reset_n)
      ack_ff |=> !ack_ff;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

  property p_err_pulse;
    @(posedge core_clk) disable iff (!reset_n)
      err_ff |=> !err_ff;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("err held too long");

  // read data is zero outside the ack cycle, so a stale word never leaks
  property p_dat_idle_zero;
    @(posedge core_clk) disable iff (!reset_n)
      !ack_ff |-> rdata_ff == 32'h00000000;
  endproperty
  a_dat_idle_zero: assert property (p_dat_idle_zero) else $error("read data not cleared");

  property p_unmapped_no_write;
    @(posedge core_clk) disable iff (!reset_n)
      req && !mapped |=> $stable(threshold_ff) && $stable(irq_mask_ff);
  endproperty
  a_unmapped_no_write: assert property (p_unmapped_no_write) else $error("unmapped write landed");

  property p_lane_gate;
    @(posedge core_clk) disable iff (!reset_n)
      req && wb_req.we && !wb_req.sel[0] |=> $stable(threshold_ff) && $stable(irq_mask_ff);
  endproperty
  a_lane_gate: assert property (p_lane_gate) else $error("write without lane 0 landed");

  property p_mask_write;
    @(posedge core_clk) disable iff (!reset_n)
      wr_mask |=> irq_mask_ff == $past(wb_req.dat[1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  ////////////////////////////////////////////////////////////////
  // interrupt status and line
  sequence s_clear_racing_set;
    wr_irqs && wb_req.dat[0] && ev_set;
  endsequence

  property p_set_beats_clear;
    @(posedge core_clk) disable iff (!reset_n)
      s_clear_racing_set |=> irq_status_ff[0];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) else $error("clear beat a new event");

  property p_w1c_clears;
    @(posedge core_clk) disable iff (!reset_n)
      wr_irqs && wb_req.dat[0] && !ev_set |=> !irq_status_ff[0];
  endproperty
  a_w1c_clears: assert property (p_w1c_clears) else $error("status bit not cleared");

  property p_irq_fall;
    @(posedge core_clk) disable iff (!reset_n)
      $fell(warn_flag) |=> irq_status_ff[1];
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("fall event not latched");

  property p_status_quiet;
    @(posedge core_clk) disable iff (!reset_n)
      !ev_set && !ev_clr && !wr_irqs |=> irq_status_ff == $past(irq_status_ff);
  endproperty
  a_status_quiet: assert property (p_status_quiet) else $error("status moved by itself");

  property p_irq_on;
    @(posedge core_clk) disable iff (!reset_n)
      (irq_status_ff[0] && irq_mask_ff[0]) || (irq_status_ff[1] && irq_mask_ff[1]) |-> irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");

  property p_irq_off;
    @(posedge core_clk) disable iff (!reset_n)
      !(irq_status_ff[0] && irq_mask_ff[0]) && !(irq_status_ff[1] && irq_mask_ff[1]) |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without unmasked status");

  // the flag only ever moves to the value the compare held at that edge
  property p_flag_follows_raw;
    @(posedge core_clk) disable iff (!reset_n)
      $changed(warn_flag) |-> warn_flag == $past(raw_below);
  endproperty
  a_flag_follows_raw: assert property (p_flag_follows_raw) else $error("flag moved wrong way");

endmodule // overtemp_warning_compare

// >>> verif/overtemp_warning_compare_test.sv
// testbench: register access, compare boundaries, debounce and interrupt of the warning block
`timescale 1ns/1ns
module overtemp_warning_compare_test;
  localparam int DB = 8;  // short debounce so the run stays brief
  logic                                     core_clk;
  logic                                     reset_n;
  temp_warn_pkg::wb_req_type                wb_req;
  temp_warn_pkg::wb_rsp_type                wb_rsp;
  logic [temp_warn_pkg::READING_WIDTH-1:0]  sensor_reading;
  logic                                     temp_warning;
  logic                                     irq;
  int                                       fail_count;
  int                                       cmp_count;
  logic [31:0]                              q;
  logic                                     e;

  overtemp_warning_compare #(.DEBOUNCE_LEN(DB)) overtemp_warning_compare_i (
    .core_clk       (core_clk),
    .reset_n        (reset_n),
    .wb_req         (wb_req),
    .wb_rsp         (wb_rsp),
    .sensor_reading (sensor_reading),
    .temp_warning   (temp_warning),
    .irq            (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 50 ns clock
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // one classic cycle; request held until ack or err is sampled high
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_req <= '{1'b1, 1'b1, w, s, a, d};
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wb_rsp.ack !== 1'b1 && wb_rsp.err !== 1'b1 && n < 50);
    q = wb_rsp.dat;
    e = wb_rsp.err;
    wb_req <= '0;
    if (n >= 50)
    begin
      fail_count++;
      $display("ERROR t=%0t bus timeout", $time);
      close_out();
    end
  endtask

  // drive a reading and watch the flag hold, then flip after the debounce
  task automatic deb(input logic [11:0] r, input logic w);
    int k;
    @(posedge core_clk);
    sensor_reading <= r;
    for (k = 1; k < DB; k++)
    begin
      @(posedge core_clk);
      #1 chk(temp_warning, !w, "flag moved early");
    end
    @(posedge core_clk);
    #1 chk(temp_warning, w, "flag did not move");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    bus(0, temp_warn_pkg::THRESHOLD_ADDR, 0, 4'hF);
    chk(q, 32'h03, "threshold reset");
    bus(0, temp_warn_pkg::IRQ_MASK_ADDR, 0, 4'hF);
    chk(q, 32'h0, "mask reset");
    bus(1, temp_warn_pkg::THRESHOLD_ADDR, 32'hFA, 4'hF);
    bus(1, temp_warn_pkg::THRESHOLD_ADDR, 32'h10, 4'h0);
    bus(0, temp_warn_pkg::THRESHOLD_ADDR, 0, 4'hF);
    chk(q, 32'hFA, "threshold write or sel");
    bus(0, 16'h3880, 0, 4'hF);
    chk({31'h0, e}, 32'h1, "unmapped err");
    $display("test regs done");
  endtask

  // table of threshold, reading and expected raw compare
  task automatic t_cmp();
    logic [31:0] tab [6] = '{32'h040_200_0, 32'h040_1FF_1, 32'h040_207_0,
                             32'h0FA_800_0, 32'h0FA_7CF_1, 32'h003_017_1};
    foreach (tab[i])
    begin
      bus(1, temp_warn_pkg::THRESHOLD_ADDR, {24'h0, tab[i][23:16]}, 4'hF);
      sensor_reading <= tab[i][15:4];
      repeat (2) @(posedge core_clk);
      bus(0, temp_warn_pkg::STATUS_ADDR, 0, 4'hF);
      chk({31'h0, q[temp_warn_pkg::STAT_RAW_BIT]}, {31'h0, tab[i][0]}, "raw");
    end
    $display("test compare done");
  endtask

  // glitch restarts the count; masked and unmasked events
  task automatic t_deb_irq();
    bus(1, temp_warn_pkg::THRESHOLD_ADDR, 32'h40, 4'hF);
    // park the flag low first: the compare table leaves it in motion
    sensor_reading <= 12'h300;
    repeat (DB + 2) @(posedge core_clk);
    bus(1, temp_warn_pkg::IRQ_STATUS_ADDR, 32'h3, 4'hF);
    bus(1, temp_warn_pkg::IRQ_MASK_ADDR, 32'h1, 4'hF);
    sensor_reading <= 12'h100;
    repeat (4) @(posedge core_clk);
    sensor_reading <= 12'h300;
    deb(12'h100, 1'b1);
    @(posedge core_clk);
    #1 chk({31'h0, irq}, 32'h1, "irq on rise");
    bus(1, temp_warn_pkg::IRQ_STATUS_ADDR, 32'h1, 4'hF);
    @(posedge core_clk);
    #1 chk({31'h0, irq}, 32'h0, "irq after clear");
    bus(0, temp_warn_pkg::STATUS_ADDR, 0, 4'hF);
    chk(q, 32'h3, "status warn and raw");
    bus(0, temp_warn_pkg::READING_ADDR, 0, 4'hF);
    chk(q, 32'h100, "reading readback");
    deb(12'h300, 1'b0);
    repeat (2) @(posedge core_clk);
    #1 chk({31'h0, irq}, 32'h0, "masked fall");
    bus(0, temp_warn_pkg::IRQ_STATUS_ADDR, 0, 4'hF);
    chk(q, 32'h2, "fall status");
    $display("test debounce irq done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    fail_count = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    wb_req = '0;
    sensor_reading = 12'hFFF;
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    #1 chk({30'h0, temp_warning, irq}, 32'h0, "outputs after reset");
    t_regs();
    t_cmp();
    t_deb_irq();
    close_out();
  end
endmodule // overtemp_warning_compare_test
